// >>> design/sss_dev.sv
`timescale 1ns/10ps
module sss_dev (
  sss_link_if.dev link,
  input wire logic clock_i,
  input wire logic sys_rst_i,
  output logic [1:0] mode_o,
  output logic pause_en_o,
  output logic selected_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  localparam sss_pkg::sss_dev_frame_t FRAME_RST = '{
    phase: sss_pkg::DEV_CMD,
    cnt: 4'h0,
    sh: 8'h00,
    addr: 15'h0000
  };

  logic [7:0] mem_q [0:sss_pkg::MEM_BYTES-1];
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic status_we;
  sss_pkg::sss_dev_frame_t frame_q;
  sss_pkg::sss_dev_frame_t frame_d;
  sss_pkg::sss_dev_out_t out_q;
  sss_pkg::sss_dev_out_t out_d;
  sss_pkg::sss_dev_sync_t sync_q;
  sss_pkg::sss_dev_sync_t sync_d;
  logic mem_we;
  logic [7:0] sample;
  logic [7:0] rd_byte;
  logic [1:0] mode;
  logic held;
  logic byte_end;
  logic [14:0] addr_next;

  // ----------------------------------------
  // Link-side decode
  // ----------------------------------------
  assign mode = {status_q[sss_pkg::STAT_MODE_HI], status_q[sss_pkg::STAT_MODE_LO]};
  assign held = ~status_q[sss_pkg::STAT_PAUSE_DIS] & ~link.hold_n;
  assign sample = {frame_q.sh[6:0], link.mosi};
  assign byte_end = frame_q.cnt == sss_pkg::BYTE_LAST_BIT;
  assign rd_byte = mem_q[frame_q.addr];

  always_comb
  begin
    case (mode)
      sss_pkg::MODE_PAGE:
        addr_next = {frame_q.addr[14:5], 5'(frame_q.addr[4:0] + 5'h01)};
      sss_pkg::MODE_SEQ:
        addr_next = 15'(frame_q.addr + 15'h0001);
      default:
        addr_next = frame_q.addr;
    endcase
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always_comb
  begin
    frame_d = frame_q;
    mem_we = 1'b0;
    status_we = 1'b0;
    status_d = {sample[7:6], 5'h00, sample[0]};
    frame_d.cnt = 4'(frame_q.cnt + 4'h1);
    case (frame_q.phase)
      sss_pkg::DEV_CMD:
      begin
        frame_d.sh = sample;
        if (byte_end)
        begin
          frame_d.cnt = 4'h0;
          case (sample)
            sss_pkg::CMD_READ: frame_d.phase = sss_pkg::DEV_ADDR_RD;
            sss_pkg::CMD_WRITE: frame_d.phase = sss_pkg::DEV_ADDR_WR;
            sss_pkg::READ_STATUS_CMD: frame_d.phase = sss_pkg::DEV_STAT_RD;
            sss_pkg::WRITE_STATUS_CMD: frame_d.phase = sss_pkg::DEV_STAT_WR;
            default: frame_d.phase = sss_pkg::DEV_IGNORE;
          endcase
        end
      end
      sss_pkg::DEV_ADDR_RD,
      sss_pkg::DEV_ADDR_WR:
      begin
        // Top address bit falls out of the 15-bit shift
        frame_d.addr = {frame_q.addr[13:0], link.mosi};
        if (frame_q.cnt == sss_pkg::ADDR_LAST_BIT)
        begin
          frame_d.cnt = 4'h0;
          frame_d.phase = (frame_q.phase == sss_pkg::DEV_ADDR_RD) ? sss_pkg::DEV_MEM_RD : sss_pkg::DEV_MEM_WR;
        end
      end
      sss_pkg::DEV_MEM_RD,
      sss_pkg::DEV_MEM_WR:
      begin
        frame_d.sh = sample;
        if (byte_end)
        begin
          mem_we = frame_q.phase == sss_pkg::DEV_MEM_WR;
          frame_d.cnt = 4'h0;
          frame_d.addr = addr_next;
          // Byte and reserved modes stop after one byte
          if (mode != sss_pkg::MODE_PAGE && mode != sss_pkg::MODE_SEQ)
            frame_d.phase = sss_pkg::DEV_IGNORE;
        end
      end
      sss_pkg::DEV_STAT_RD:
      begin
        // Status repeats for as long as the host clocks
        if (byte_end)
          frame_d.cnt = 4'h0;
      end
      sss_pkg::DEV_STAT_WR:
      begin
        frame_d.sh = sample;
        if (byte_end)
        begin
          status_we = 1'b1;
          frame_d.phase = sss_pkg::DEV_IGNORE;
        end
      end
      sss_pkg::DEV_IGNORE: frame_d.cnt = frame_q.cnt;
      default: frame_d.phase = sss_pkg::DEV_IGNORE;
    endcase
    if (held)
    begin
      // Edges during pause leave every bit of state alone
      frame_d = frame_q;
      mem_we = 1'b0;
      status_we = 1'b0;
    end
  end

  // Select going high clears the frame without needing a clock edge
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      frame_q <= FRAME_RST;
    end
    else
    begin
      frame_q <= frame_d;
    end
  end

  always_ff @(posedge link.sck)
  begin
    if (mem_we && !link.cs_n)
    begin
      mem_q[frame_q.addr] <= sample;
    end
  end

  // Link clock stands still at reset, so status clears without it
  always_ff @(posedge link.sck or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      status_q <= sss_pkg::STAT_RESET;
    end
    else if (status_we && !link.cs_n)
    begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  always_comb
  begin
    out_d = out_q;
    if (!held)
    begin
      case (frame_q.phase)
        sss_pkg::DEV_MEM_RD:
        begin
          out_d.so = rd_byte[3'(~frame_q.cnt[2:0])];
          out_d.drive = 1'b1;
        end
        sss_pkg::DEV_STAT_RD:
        begin
          out_d.so = status_q[3'(~frame_q.cnt[2:0])];
          out_d.drive = 1'b1;
        end
        default:
        begin
          out_d.so = 1'b0;
          out_d.drive = 1'b0;
        end
      endcase
    end
  end

  // Output moves on the falling edge so the host samples a settled bit
  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      out_q <= '0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  assign link.miso = out_q.so;
  assign link.miso_oe = ~link.cs_n & out_q.drive & ~held;

  // ----------------------------------------
  // System-side view
  // ----------------------------------------
  always_comb
  begin
    // Mode only moves while selected, so both bits are taken together once deselect is seen
    sync_d.mode_hi_s1 = sync_q.sel_s2 ? sync_q.mode_hi_s1 : mode[1];
    sync_d.mode_hi_s2 = sync_q.mode_hi_s1;
    sync_d.mode_lo_s1 = sync_q.sel_s2 ? sync_q.mode_lo_s1 : mode[0];
    sync_d.mode_lo_s2 = sync_q.mode_lo_s1;
    sync_d.pen_s1 = ~status_q[sss_pkg::STAT_PAUSE_DIS];
    sync_d.pen_s2 = sync_q.pen_s1;
    sync_d.sel_s1 = ~link.cs_n;
    sync_d.sel_s2 = sync_q.sel_s1;
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      sync_q <= '0;
    end
    else
    begin
      sync_q <= sync_d;
    end
  end

  assign mode_o = {sync_q.mode_hi_s2, sync_q.mode_lo_s2};
  assign pause_en_o = sync_q.pen_s2;
  assign selected_o = sync_q.sel_s2;

endmodule : sss_dev

// >>> pkg/sss_pkg.sv
package sss_pkg;

  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int MEM_BYTES = 32768;
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 5;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;

  // ----------------------------------------
  // Status register layout
  // ----------------------------------------
  localparam int STAT_MODE_HI = 7;
  localparam int STAT_MODE_LO = 6;
  localparam int STAT_PAUSE_DIS = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_SEQ = 2'h1;

  // ----------------------------------------
  // Frame counts
  // ----------------------------------------
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] ADDR_LAST_BIT = 4'hF;
  localparam logic [2:0] HDR_WITH_ADDR = 3'h3;
  localparam logic [2:0] HDR_NO_ADDR = 3'h1;

  // ----------------------------------------
  // Host serial clock timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_HALF_NS = 32;
  localparam int SCK_HALF_CYC_INT = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC_INT - 1);

  // ----------------------------------------
  // Device sequence state
  // ----------------------------------------
  typedef enum logic [2:0] {
    DEV_CMD,
    DEV_ADDR_RD,
    DEV_ADDR_WR,
    DEV_MEM_RD,
    DEV_MEM_WR,
    DEV_STAT_RD,
    DEV_STAT_WR,
    DEV_IGNORE
  } sss_dev_phase_t;

  typedef struct packed {
    sss_dev_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [14:0] addr;
  } sss_dev_frame_t;

  typedef struct packed {
    logic so;
    logic drive;
  } sss_dev_out_t;

  typedef struct packed {
    logic mode_hi_s1;
    logic mode_hi_s2;
    logic mode_lo_s1;
    logic mode_lo_s2;
    logic pen_s1;
    logic pen_s2;
    logic sel_s1;
    logic sel_s2;
  } sss_dev_sync_t;

  // ----------------------------------------
  // Host state
  // ----------------------------------------
  typedef enum logic [2:0] {
    HST_IDLE,
    HST_LOW,
    HST_HIGH,
    HST_PAUSE,
    HST_TAIL
  } sss_hst_state_t;

  typedef struct packed {
    sss_hst_state_t state;
    logic [3:0] div;
    logic [2:0] bitn;
    logic [8:0] idx;
    logic [8:0] total;
    logic has_addr;
    logic [15:0] addr;
    logic [7:0] tx;
    logic [7:0] rx;
    logic sck;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic [7:0] rdata;
    logic rvld;
    logic take;
    logic so_s1;
    logic so_s2;
  } sss_hst_t;

endpackage : sss_pkg

// >>> pkg/sss_link_if.sv
`timescale 1ns/10ps
interface sss_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic hold_n;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Undriven line shows the inverse of the last bit, so a late sample is caught
  assign miso_line = miso_oe ? miso : ~miso;

  modport host (
    output sck,
    output cs_n,
    output mosi,
    output hold_n,
    input miso_line
  );

  modport dev (
    input sck,
    input cs_n,
    input mosi,
    input hold_n,
    output miso,
    output miso_oe
  );
endinterface : sss_link_if

// >>> design/sss_host.sv
`timescale 1ns/10ps
module sss_host (
  sss_link_if.host link,
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic req_i,
  input wire logic [7:0] instr_i,
  input wire logic has_addr_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] nbytes_i,
  input wire logic [7:0] wdata_i,
  input wire logic pause_i,
  output logic ready_o,
  output logic wdata_take_o,
  output logic [7:0] rdata_o,
  output logic rdata_vld_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sss_pkg::sss_hst_t q;
  sss_pkg::sss_hst_t d;
  logic [8:0] nidx;
  logic [8:0] hdr;
  logic [7:0] next_byte;
  logic next_is_data;

  assign nidx = 9'(q.idx + 9'h001);
  assign hdr = {6'h00, q.has_addr ? sss_pkg::HDR_WITH_ADDR : sss_pkg::HDR_NO_ADDR};

  always_comb
  begin
    next_is_data = 1'b1;
    next_byte = wdata_i;
    if (q.has_addr && nidx == 9'h001)
    begin
      next_is_data = 1'b0;
      next_byte = q.addr[15:8];
    end
    else if (q.has_addr && nidx == 9'h002)
    begin
      next_is_data = 1'b0;
      next_byte = q.addr[7:0];
    end
  end

  // ----------------------------------------
  // Serial clock and framing
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.so_s1 = link.miso_line;
    d.so_s2 = q.so_s1;
    d.rvld = 1'b0;
    d.take = 1'b0;
    d.div = 4'(q.div + 4'h1);
    case (q.state)
      sss_pkg::HST_IDLE:
      begin
        d.div = 4'h0;
        d.cs_n = 1'b1;
        d.sck = 1'b0;
        d.hold_n = 1'b1;
        if (req_i)
        begin
          d.state = sss_pkg::HST_LOW;
          d.cs_n = 1'b0;
          d.tx = instr_i;
          d.mosi = instr_i[7];
          d.addr = addr_i;
          d.has_addr = has_addr_i;
          d.total = 9'({6'h00, has_addr_i ? sss_pkg::HDR_WITH_ADDR : sss_pkg::HDR_NO_ADDR} + {1'b0, nbytes_i});
          d.idx = 9'h000;
          d.bitn = 3'h0;
        end
      end
      sss_pkg::HST_LOW:
      begin
        if (q.div == sss_pkg::SCK_HALF_LAST)
        begin
          d.div = 4'h0;
          if (pause_i)
          begin
            // Pause only starts with the clock low
            d.state = sss_pkg::HST_PAUSE;
            d.hold_n = 1'b0;
          end
          else
          begin
            d.state = sss_pkg::HST_HIGH;
            d.sck = 1'b1;
            d.rx = {q.rx[6:0], q.so_s2};
          end
        end
      end
      sss_pkg::HST_PAUSE:
      begin
        d.div = 4'h0;
        if (!pause_i)
        begin
          d.hold_n = 1'b1;
          d.state = sss_pkg::HST_LOW;
        end
      end
      sss_pkg::HST_HIGH:
      begin
        if (q.div == sss_pkg::SCK_HALF_LAST)
        begin
          d.div = 4'h0;
          d.sck = 1'b0;
          d.bitn = 3'(q.bitn + 3'h1);
          d.tx = {q.tx[6:0], 1'b0};
          d.mosi = q.tx[6];
          d.state = sss_pkg::HST_LOW;
          if (q.bitn == 3'h7)
          begin
            d.idx = nidx;
            if (q.idx >= hdr)
            begin
              d.rdata = q.rx;
              d.rvld = 1'b1;
            end
            if (nidx == q.total)
            begin
              d.state = sss_pkg::HST_TAIL;
              d.cs_n = 1'b1;
            end
            else
            begin
              d.tx = next_byte;
              d.mosi = next_byte[7];
              d.take = next_is_data;
            end
          end
        end
      end
      sss_pkg::HST_TAIL:
      begin
        // Keeps select high for a half period before the next frame
        if (q.div == sss_pkg::SCK_HALF_LAST)
        begin
          d.state = sss_pkg::HST_IDLE;
        end
      end
      default:
      begin
        d.state = sss_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      q <= '{state: sss_pkg::HST_IDLE, cs_n: 1'b1, hold_n: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign link.sck = q.sck;
  assign link.cs_n = q.cs_n;
  assign link.mosi = q.mosi;
  assign link.hold_n = q.hold_n;
  assign ready_o = q.state == sss_pkg::HST_IDLE;
  assign wdata_take_o = q.take;
  assign rdata_o = q.rdata;
  assign rdata_vld_o = q.rvld;

endmodule : sss_host

// >>> test/sss_link_monitor.sv
`timescale 1ns/10ps
module sss_link_monitor (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic hold_n,
  input wire logic miso,
  input wire logic miso_oe
);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  default clocking mon_cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_desel_float: assert property (cs_n |-> !miso_oe)
    else $error("Output driven while deselected");
  chk_sck_idle: assert property (cs_n |-> !sck)
    else $error("Serial clock not idle low");
  chk_mosi_settled: assert property ($rose(sck) |-> $stable(mosi))
    else $error("Input data moved at rising clock");
  chk_high_half: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
    else $error("Clock high half not eight cycles");
  chk_first_rise: assert property ($fell(cs_n) |-> !sck [*8] ##1 sck)
    else $error("First rise not eight cycles after select");
  chk_cs_tail: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("Deselect shorter than eight cycles");
  chk_miso_fall: assert property ((miso_oe && $past(miso_oe) && $changed(miso)) |-> (!sck && $past(sck)))
    else $error("Output changed away from falling clock");
  chk_hold_sel: assert property (!hold_n |-> !cs_n)
    else $error("Pause while deselected");
  chk_hold_enter: assert property ($fell(hold_n) |-> !sck && !$past(sck))
    else $error("Pause entered with clock high");
  chk_pause_still: assert property ((!hold_n && !$past(hold_n)) |-> $stable(sck) && $stable(mosi))
    else $error("Link moved during pause");
  chk_resume_low: assert property ($rose(hold_n) |-> !sck [*4])
    else $error("Resume without fresh low half");
endmodule : sss_link_monitor

// >>> test/spi_serial_sram_slave_tb.sv
`timescale 1ns/10ps
module spi_serial_sram_slave_tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic req_i = 1'b0;
  logic [7:0] instr_i = 8'h00;
  logic has_addr_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] nbytes_i = 8'h00;
  logic [7:0] wdata_i;
  logic pause_i = 1'b0;
  logic ready_o;
  logic wdata_take_o;
  logic [7:0] rdata_o;
  logic rdata_vld_o;
  logic [1:0] mode_o;
  logic pause_en_o;
  logic selected_o;
  logic [7:0] wbuf [0:63];
  logic [7:0] rbuf [0:63];
  logic [7:0] ref_mem [0:32767];
  logic [1:0] mode_m = 2'h0;
  logic oe_held = 1'b0;
  int wk = 0;
  int rk = 0;
  int mismatches = 0;
  int tests_run = 0;

  always #2 clock_i = ~clock_i;
  assign wdata_i = wbuf[wk];

  sss_link_if lnk ();
  sss_host sss_host_inst (
    .link(lnk),
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .req_i(req_i),
    .instr_i(instr_i),
    .has_addr_i(has_addr_i),
    .addr_i(addr_i),
    .nbytes_i(nbytes_i),
    .wdata_i(wdata_i),
    .pause_i(pause_i),
    .ready_o(ready_o),
    .wdata_take_o(wdata_take_o),
    .rdata_o(rdata_o),
    .rdata_vld_o(rdata_vld_o)
  );
  sss_dev sss_dev_inst (
    .link(lnk),
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .mode_o(mode_o),
    .pause_en_o(pause_en_o),
    .selected_o(selected_o)
  );
  sss_link_monitor sss_link_monitor_inst (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .sck(lnk.sck),
    .cs_n(lnk.cs_n),
    .mosi(lnk.mosi),
    .hold_n(lnk.hold_n),
    .miso(lnk.miso),
    .miso_oe(lnk.miso_oe)
  );

  // ----------------------------------------
  // Capture and access tasks
  // ----------------------------------------
  always @(negedge wdata_take_o)
  begin
    #1;
    wk = wk + 1;
  end
  always @(posedge clock_i)
  begin
    if (rdata_vld_o === 1'b1)
    begin
      rbuf[rk] = rdata_o;
      rk = rk + 1;
    end
    if (lnk.hold_n === 1'b0 && lnk.miso_oe !== 1'b0)
      oe_held = 1'b1;
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  function automatic logic multi();
    return mode_m == sss_pkg::MODE_PAGE || mode_m == sss_pkg::MODE_SEQ;
  endfunction : multi

  function automatic logic [14:0] nxt(input logic [14:0] a);
    if (mode_m == sss_pkg::MODE_PAGE)
      return {a[14:5], a[4:0] + 5'h01};
    return a + 15'h0001;
  endfunction : nxt

  task automatic xfer(input logic [7:0] ins, input logic ha, input logic [15:0] a, input int n, input int pz);
    int t;
    @(posedge clock_i);
    #1;
    wk = 0;
    rk = 0;
    instr_i = ins;
    has_addr_i = ha;
    addr_i = a;
    nbytes_i = 8'(n);
    req_i = 1'b1;
    @(posedge clock_i);
    #1;
    req_i = 1'b0;
    t = 0;
    while (ready_o !== 1'b1 && t < 20000)
    begin
      if (t == pz)
        pause_i = 1'b1;
      if (t == pz + 200)
        pause_i = 1'b0;
      if (t == 100)
        chk1("selected", 1'b1, selected_o);
      @(posedge clock_i);
      #1;
      t++;
    end
    if (t >= 20000)
      chk1("transfer done", 1'b1, ready_o);
  endtask : xfer

  task automatic wr(input logic [15:0] a, input int n);
    logic [14:0] p;
    p = a[14:0];
    for (int i = 0; i < n; i++)
    begin
      if (i == 0 || multi())
        ref_mem[p] = wbuf[i];
      p = nxt(p);
    end
    xfer(sss_pkg::CMD_WRITE, 1'b1, a, n, -1);
  endtask : wr

  task automatic rd(input logic [15:0] a, input int n, input int pz);
    logic [14:0] p;
    xfer(sss_pkg::CMD_READ, 1'b1, a, n, pz);
    p = a[14:0];
    for (int i = 0; i < n; i++)
    begin
      if (i == 0 || multi())
        chk8("read data", ref_mem[p], rbuf[i]);
      p = nxt(p);
    end
  endtask : rd

  task automatic wrstat(input logic [7:0] v);
    wbuf[0] = v;
    xfer(sss_pkg::WRITE_STATUS_CMD, 1'b0, 16'h0000, 1, -1);
    mode_m = v[7:6];
    repeat (4) @(posedge clock_i);
    #1;
  endtask : wrstat

  task automatic rdstat(input logic [7:0] e);
    xfer(sss_pkg::READ_STATUS_CMD, 1'b0, 16'h0000, 2, -1);
    chk8("status", e, rbuf[0]);
    chk8("status repeat", e, rbuf[1]);
  endtask : rdstat

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    #240000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    // Raised after time zero so the asynchronous status clear sees an edge
    #1;
    sys_rst_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    chk8("mode", 8'h00, {6'h00, mode_o});
    chk1("pause enable", 1'b1, pause_en_o);
    chk1("selected", 1'b0, selected_o);
    rdstat(8'h00);
    wbuf[0] = 8'h5A;
    wr(16'h0101, 1);
    wbuf[0] = 8'hC3;
    wbuf[1] = 8'h3C;
    wr(16'h8100, 2);
    rd(16'h0100, 1, -1);
    rd(16'h0101, 1, -1);
    wrstat(8'h82);
    chk8("mode", 8'h02, {6'h00, mode_o});
    rdstat(8'h80);
    for (int i = 0; i < 34; i++)
      wbuf[i] = 8'(i + 16);
    wr(16'h005E, 34);
    rd(16'h0040, 33, -1);
    wrstat(8'h40);
    chk8("mode", 8'h01, {6'h00, mode_o});
    for (int i = 0; i < 4; i++)
      wbuf[i] = 8'(8'hA0 + i);
    wr(16'h7FFE, 4);
    oe_held = 1'b0;
    rd(16'hFFFE, 4, 500);
    chk1("drive in pause", 1'b0, oe_held);
    wrstat(8'h41);
    chk1("pause enable", 1'b0, pause_en_o);
    oe_held = 1'b0;
    rd(16'h7FFF, 2, 500);
    chk1("drive with pause off", 1'b1, oe_held);
    wrstat(8'hC0);
    rdstat(8'hC0);
    wbuf[0] = 8'h11;
    wr(16'h0201, 1);
    wbuf[0] = 8'h22;
    wbuf[1] = 8'h33;
    wr(16'h0200, 2);
    rd(16'h0201, 1, -1);
    wrstat(8'h00);
    wbuf[0] = 8'hFF;
    wbuf[1] = 8'hFF;
    xfer(8'hA5, 1'b1, 16'h0100, 2, -1);
    rd(16'h0100, 1, -1);
    rdstat(8'h00);
    end_of_test();
  end
endmodule : spi_serial_sram_slave_tb
